/* flash_ctrl_pkg.sv */
// constants and carrier types for the program flash controller
// assumes one system clock and a register-file write/read port from the core
// Function
// - pages of 512 bytes, smallest erase unit
// - each page holds eight 64-byte rows
// - sectors span one, two or three pages
// - flash sizes 1K/2K/4K/8K or 12K
// - lowest two bytes hold option bits
// - code 5eh maps protect register at ff9h
// - other codes restore page select at ff9h
// - protect register bits only set; only reset clears them
// - protect register resets to zero
// - protected sector refuses program and erase
// - programming needs unlock plus erase enable
// - mass enable anywhere, page enable selected page
// - erased reads ffh, program clears bits only
// - core stalls while a byte programs
// - other control writes end programming, relock
`default_nettype none

package flash_ctrl_pkg;

  // ******************************
  // register file map
  // ******************************
  localparam logic [11:0] FLASH_CTRL_ADDR   = 12'hff8;
  localparam logic [11:0] PAGE_SEL_ADDR     = 12'hff9;
  localparam logic [7:0]  PROTECT_RESET     = 8'h00;
  localparam logic [7:0]  PAGE_SEL_RESET    = 8'h00;

  // ******************************
  // control register codes
  // ******************************
  localparam logic [7:0] CMD_RESET          = 8'h00;
  localparam logic [7:0] CMD_SEL_PROTECT    = 8'h5e;
  localparam logic [7:0] CMD_UNLOCK_1       = 8'h73;
  localparam logic [7:0] CMD_UNLOCK_2       = 8'h8c;
  localparam logic [7:0] CMD_PAGE_ERASE     = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE     = 8'h63;

  // ******************************
  // geometry
  // ******************************
  localparam int PAGE_BYTES   = 512;
  localparam int ROW_BYTES    = 64;
  localparam int ROWS_PER_PG  = PAGE_BYTES / ROW_BYTES;
  localparam int OPTION_BYTES = 2;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ******************************
  // timing
  // ******************************
  localparam int CLK_HZ       = 25_000_000;
  localparam int PROG_TIME_NS = 1000;
  localparam int PROG_CYCLES  =
    (PROG_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int ERASE_CYCLES = 16;

  typedef enum logic [4:0] {
    ST_LOCKED  = 5'b00001,
    ST_UNLK1   = 5'b00010,
    ST_UNLK2   = 5'b00100,
    ST_ENABLED = 5'b01000,
    ST_BUSY    = 5'b10000
  } ctrl_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic        wr;
    logic [13:0] addr;
    logic [7:0]  wdata;
  } prog_req_t;

endpackage

`default_nettype wire

/* flash_array.sv */
// flash byte array with program-clears-bits and page erase
// assumes requests are already checked by the controller
`default_nettype none

module flash_array #(
  parameter int ADDR_W = 14,
  parameter int BYTES  = 12288
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // program port
  input  wire logic              prog_i,
  input  wire logic [ADDR_W-1:0] prog_addr_i,
  input  wire logic [7:0]        prog_data_i,
  // erase port
  input  wire logic              erase_i,
  input  wire logic              erase_all_i,
  input  wire logic [ADDR_W-1:0] erase_base_i,
  // read port
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [7:0]        rd_data_o
);

  logic [7:0] mem [BYTES];
  logic [ADDR_W-1:0] pg_base;
  assign pg_base = erase_base_i;

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < BYTES; i++) begin
      if (erase_i && (erase_all_i ||
          (i >= int'(pg_base) &&
           i < int'(pg_base) + flash_ctrl_pkg::PAGE_BYTES))) begin
        mem[i] <= flash_ctrl_pkg::ERASED_BYTE;
      end else if (prog_i && int'(prog_addr_i) == i) begin
        mem[i] <= mem[i] & prog_data_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rd_data_o <= flash_ctrl_pkg::ERASED_BYTE;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule // flash_array

`default_nettype wire

/* flash_program_protect_ctrl.sv */
// program flash controller: unlock, erase enables, sector protect, stall
// assumes register writes and program requests in the system clock domain
`default_nettype none

module flash_program_protect_ctrl #(
  parameter int FLASH_KB = 12,
  parameter int ADDR_W   = 14
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  // register file port
  input  wire flash_ctrl_pkg::reg_req_t   reg_req_i,
  output logic      [7:0]                 reg_rdata_o,
  output logic                            reg_hit_o,
  // program memory writes from core or debugger, and the array read port
  input  wire flash_ctrl_pkg::prog_req_t  prog_req_i,
  input  wire logic [ADDR_W-1:0]          rd_addr_i,
  output logic      [7:0]                 rd_data_o,
  // core control and status
  output logic                            cpu_stall_o,
  output logic                            prog_enabled_o,
  output logic                            option_byte_o
);

  // ******************************
  // geometry per variant
  // ******************************
  localparam int BYTES = FLASH_KB * 1024;
  localparam int PAGES = BYTES / flash_ctrl_pkg::PAGE_BYTES;
  localparam int PG_PER_SEC = (FLASH_KB == 12) ? 3 :
                              (FLASH_KB == 8) ? 2 : 1;
  // twelve kilobytes give 24 pages in 8 sectors, one per protect bit
  localparam int SECTORS = PAGES / PG_PER_SEC;
  // byte offset bits inside a page and inside a row
  localparam int PG_SHIFT  = $clog2(flash_ctrl_pkg::PAGE_BYTES);
  localparam int ROW_SHIFT = $clog2(flash_ctrl_pkg::ROW_BYTES);
  localparam int PG_W      = ADDR_W - PG_SHIFT;

  flash_ctrl_pkg::ctrl_state_t state;
  flash_ctrl_pkg::ctrl_state_t next_state;
  logic [7:0]  protect;
  logic [7:0]  page_sel;
  logic        protect_sel;
  logic        mass_mode;
  logic [7:0]  busy_cnt;
  logic        erase_pend;
  logic        erase_all;

  // ******************************
  // register decode
  // ******************************
  wire ctrl_wr = reg_req_i.wr &&
                 reg_req_i.addr == flash_ctrl_pkg::FLASH_CTRL_ADDR;
  wire sel_wr  = reg_req_i.wr &&
                 reg_req_i.addr == flash_ctrl_pkg::PAGE_SEL_ADDR;
  wire [7:0] code = reg_req_i.wdata;
  wire is_erase_cmd = code == flash_ctrl_pkg::CMD_PAGE_ERASE ||
                      code == flash_ctrl_pkg::CMD_MASS_ERASE;

  // ******************************
  // address checks
  // ******************************
  wire [PG_W-1:0] req_page =
    prog_req_i.addr[ADDR_W-1:PG_SHIFT];
  wire [PG_SHIFT-ROW_SHIFT-1:0] req_row =
    prog_req_i.addr[PG_SHIFT-1:ROW_SHIFT];
  wire [7:0] req_sector = 8'(int'(req_page) / PG_PER_SEC);
  wire [7:0] sel_sector = 8'(int'(page_sel[PG_W-1:0]) / PG_PER_SEC);
  wire req_in_range = int'(prog_req_i.addr) < BYTES;
  wire req_protected = req_sector < 8'(SECTORS) &&
                       protect[req_sector[2:0]];
  wire page_ok = mass_mode || req_page == page_sel[PG_W-1:0];
  wire prog_ok = prog_req_i.wr && state == flash_ctrl_pkg::ST_ENABLED &&
                 req_in_range && !req_protected && page_ok;
  // a control write in the same cycle wins over a program request;
  // busy is then never entered without a loaded timer
  wire prog_go = prog_ok && !ctrl_wr;
  wire erase_all_i_w = code == flash_ctrl_pkg::CMD_MASS_ERASE;
  // mass erase would wipe protected sectors too, so any set bit blocks it
  wire erase_refused = erase_all_i_w ? (|protect)
                                     : protect[sel_sector[2:0]];
  wire erase_go = ctrl_wr && is_erase_cmd &&
                  (state == flash_ctrl_pkg::ST_UNLK2) &&
                  !erase_refused;

  // lets the core see writes that land in the option bytes
  assign option_byte_o = prog_req_i.wr &&
    int'(prog_req_i.addr) < flash_ctrl_pkg::OPTION_BYTES;

  // ******************************
  // state machine
  // ******************************
  always_comb begin
    next_state = state;
    case (state)
      flash_ctrl_pkg::ST_LOCKED: begin
        if (ctrl_wr && code == flash_ctrl_pkg::CMD_UNLOCK_1)
          next_state = flash_ctrl_pkg::ST_UNLK1;
      end
      flash_ctrl_pkg::ST_UNLK1: begin
        if (ctrl_wr)
          next_state = (code == flash_ctrl_pkg::CMD_UNLOCK_2) ?
            flash_ctrl_pkg::ST_UNLK2 : flash_ctrl_pkg::ST_LOCKED;
      end
      flash_ctrl_pkg::ST_UNLK2: begin
        // a refused erase relocks instead of waiting for another code
        if (ctrl_wr)
          next_state = erase_go ? flash_ctrl_pkg::ST_BUSY
                                : flash_ctrl_pkg::ST_LOCKED;
      end
      flash_ctrl_pkg::ST_ENABLED: begin
        if (ctrl_wr && !is_erase_cmd)
          next_state = flash_ctrl_pkg::ST_LOCKED;
        else if (prog_go)
          next_state = flash_ctrl_pkg::ST_BUSY;
      end
      flash_ctrl_pkg::ST_BUSY: begin
        // leaving at one makes busy last exactly the loaded count
        if (busy_cnt == 8'h01)
          next_state = flash_ctrl_pkg::ST_ENABLED;
      end
      default: next_state = flash_ctrl_pkg::ST_LOCKED;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= flash_ctrl_pkg::ST_LOCKED;
    end else begin
      state <= next_state;
    end
  end

  // ******************************
  // busy timer and erase latch
  // ******************************
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      busy_cnt   <= 8'h00;
      erase_pend <= 1'b0;
      erase_all  <= 1'b0;
      mass_mode  <= 1'b0;
    end else begin
      erase_pend <= erase_go;
      if (erase_go) begin
        busy_cnt  <= 8'(flash_ctrl_pkg::ERASE_CYCLES);
        erase_all <= erase_all_i_w;
        mass_mode <= erase_all_i_w;
      end else if (prog_go) begin
        busy_cnt <= 8'(flash_ctrl_pkg::PROG_CYCLES);
      end else if (busy_cnt != 8'h00) begin
        busy_cnt <= busy_cnt - 8'h01;
      end
    end
  end

  // taken straight from state so it drops in the cycle busy ends
  assign cpu_stall_o    = state == flash_ctrl_pkg::ST_BUSY;
  assign prog_enabled_o = state == flash_ctrl_pkg::ST_ENABLED;

  // ******************************
  // protect select, page select, protect bits
  // ******************************
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      protect_sel <= 1'b0;
      protect     <= flash_ctrl_pkg::PROTECT_RESET;
      page_sel    <= flash_ctrl_pkg::PAGE_SEL_RESET;
    end else begin
      if (ctrl_wr)
        protect_sel <= code == flash_ctrl_pkg::CMD_SEL_PROTECT;
      // protect bits only accumulate; nothing but reset clears them
      // page select is frozen while busy so an erase cannot move
      if (sel_wr && protect_sel)
        protect <= protect | reg_req_i.wdata;
      else if (sel_wr && state != flash_ctrl_pkg::ST_BUSY)
        page_sel <= reg_req_i.wdata;
    end
  end

  // register read: protect shadows page select while selected
  wire [7:0] sel_view = protect_sel ? protect : page_sel;
  wire [7:0] ctrl_view = {3'b000, state};

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
      reg_hit_o   <= 1'b0;
    end else begin
      reg_hit_o   <= reg_req_i.rd &&
        (reg_req_i.addr == flash_ctrl_pkg::PAGE_SEL_ADDR ||
         reg_req_i.addr == flash_ctrl_pkg::FLASH_CTRL_ADDR);
      reg_rdata_o <= (reg_req_i.addr == flash_ctrl_pkg::PAGE_SEL_ADDR) ?
                     sel_view : ctrl_view;
    end
  end

  // ******************************
  // array
  // ******************************
  wire [ADDR_W-1:0] erase_base = {page_sel[PG_W-1:0], {PG_SHIFT{1'b0}}};

  flash_array #(
    .ADDR_W (ADDR_W),
    .BYTES  (BYTES)
  ) u_array (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .prog_i       (prog_go),
    .prog_addr_i  (prog_req_i.addr),
    .prog_data_i  (prog_req_i.wdata),
    .erase_i      (erase_pend),
    .erase_all_i  (erase_all),
    .erase_base_i (erase_base),
    .rd_addr_i    (rd_addr_i),
    .rd_data_o    (rd_data_o)
  );

  // rows carry no control of their own; the index is only decoded
  wire unused_ok = &{1'b0, req_row};

endmodule // flash_program_protect_ctrl

`default_nettype wire

/* flash_ctrl_monitor.sv */
// port checker for the program flash controller
// assumes one clock; bound onto every controller instance
`default_nettype none
module flash_ctrl_monitor (
  // watched ports
  input wire logic                      clk_i,
  input wire logic                      rst_b_i,
  input wire flash_ctrl_pkg::reg_req_t  reg_req_i,
  input wire logic [7:0]                reg_rdata_o,
  input wire logic                      reg_hit_o,
  input wire flash_ctrl_pkg::prog_req_t prog_req_i,
  input wire logic                      cpu_stall_o,
  input wire logic                      prog_enabled_o,
  input wire logic                      option_byte_o
);
  // ************************
  // properties
  // ************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] run;
  wire logic  ctl_wr = reg_req_i.wr && reg_req_i.addr == 12'hff8;
  wire logic  ers = reg_req_i.wdata inside {8'h95, 8'h63};
  // ff8h and ff9h share all upper address bits
  wire logic  mine = reg_req_i.addr[11:1] == 11'h7fc;
  always_ff @(posedge clk_i) begin
    run <= (!rst_b_i || !cpu_stall_o) ? 8'h00 : run + 8'h01;
  end
  sequence s_held; cpu_stall_o [*8]; endsequence
  property p_rst; $rose(rst_b_i) |-> !cpu_stall_o && !prog_enabled_o
    && !reg_hit_o && reg_rdata_o == 8'h00; endproperty
  a_rst: assert property (p_rst)
    else $error("outputs busy after reset");
  property p_hit; reg_hit_o == $past(reg_req_i.rd && mine); endproperty
  a_hit: assert property (p_hit)
    else $error("hit does not follow read address");
  property p_lock; !prog_enabled_o && !cpu_stall_o && !reg_req_i.wr
    |=> !cpu_stall_o; endproperty
  a_lock: assert property (p_lock)
    else $error("busy started while locked");
  property p_held; $rose(cpu_stall_o) |-> s_held; endproperty
  a_held: assert property (p_held)
    else $error("stall too short");
  property p_max; run <= 8'd25; endproperty
  a_max: assert property (p_max)
    else $error("stall too long");
  property p_relock; prog_enabled_o && !cpu_stall_o && ctl_wr && !ers
    |=> !prog_enabled_o; endproperty
  a_relock: assert property (p_relock)
    else $error("control write did not relock");
  property p_en; $rose(prog_enabled_o) |-> $past(cpu_stall_o); endproperty
  a_en: assert property (p_en)
    else $error("enabled without erase");
  property p_opt; prog_req_i.wr |->
    option_byte_o == (prog_req_i.addr < 14'h0002); endproperty
  a_opt: assert property (p_opt)
    else $error("option byte flag wrong");
endmodule // flash_ctrl_monitor
bind flash_program_protect_ctrl flash_ctrl_monitor mon_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
  .prog_req_i(prog_req_i), .cpu_stall_o(cpu_stall_o),
  .prog_enabled_o(prog_enabled_o), .option_byte_o(option_byte_o));
`default_nettype wire

/* core_requester.sv */
// request side: core constant stores and debugger writes
// assumes the bench calls its tasks at a falling clock edge
`default_nettype none
module core_requester (
  // clock and answers
  input  wire logic                      clk_i,
  input  wire logic [7:0]                reg_rdata_i,
  input  wire logic                      reg_hit_i,
  // requests
  output var  flash_ctrl_pkg::reg_req_t  reg_req_o,
  output var  flash_ctrl_pkg::prog_req_t prog_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************
  // bus cycles
  // ************************
  initial reg_req_o = '0;
  initial prog_req_o = '0;
  // idle fields flip so a stale value never looks valid
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    reg_req_o <= '{1'b1, 1'b0, a, d};
    @(negedge clk_i);
    reg_req_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [8:0] q);
    reg_req_o <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_i);
    reg_req_o <= '{1'b0, 1'b0, ~a, 8'hff};
    q = {reg_hit_i, reg_rdata_i};
    @(negedge clk_i);
  endtask
  // callers program a byte at most twice between erases
  task automatic prog(input logic [13:0] a, input logic [7:0] d);
    prog_req_o <= '{1'b1, a, d};
    @(negedge clk_i);
    prog_req_o <= '{1'b0, ~a, ~d};
  endtask
endmodule // core_requester
`default_nettype wire

/* testbench.sv */
// self-checking bench for the program flash controller
// assumes package, design, checker and requester model compiled
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************
  // harness
  // ************************
  logic                      clk_i = 1'b0;
  logic                      rst_b_i = 1'b0;
  logic [13:0]               rd_addr_i = 14'h0000;
  flash_ctrl_pkg::reg_req_t  reg_req;
  flash_ctrl_pkg::prog_req_t prog_req;
  logic [7:0]                reg_rdata, rd_data;
  logic                      reg_hit, stall, enabled;
  int                        miscompares = 0;
  int                        compares = 0;
  always #20 clk_i = ~clk_i;
  flash_program_protect_ctrl flash_program_protect_ctrl_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req),
    .reg_rdata_o(reg_rdata), .reg_hit_o(reg_hit), .prog_req_i(prog_req),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data), .cpu_stall_o(stall),
    .prog_enabled_o(enabled), .option_byte_o());
  core_requester core_requester_i (
    .clk_i(clk_i), .reg_rdata_i(reg_rdata), .reg_hit_i(reg_hit),
    .reg_req_o(reg_req), .prog_req_o(prog_req));
  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // counts busy cycles; a stuck stall ends the run
  task automatic idle(input int e);
    int n;
    n = 0;
    while (stall !== 1'b0) begin
      n++;
      if (n > 60) begin
        miscompares++;
        complete_run();
      end
      @(negedge clk_i);
    end
    @(negedge clk_i);
    chk(16'(n), 16'(e));
  endtask
  task automatic w(input logic [11:0] a, input logic [7:0] d, input int e);
    core_requester_i.wr_reg(a, d);
    idle(e);
  endtask
  task automatic p(input logic [13:0] a, input logic [7:0] d, input int e);
    core_requester_i.prog(a, d);
    idle(e);
  endtask
  // unmapped reads only check the hit flag
  task automatic r(input logic [11:0] a, input logic [8:0] e);
    logic [8:0] q;
    core_requester_i.rd_reg(a, q);
    if (!e[8]) q[7:0] = e[7:0];
    chk(16'(q), 16'(e));
  endtask
  task automatic f(input logic [13:0] a, input logic [7:0] e);
    rd_addr_i <= a;
    @(negedge clk_i);
    chk(16'(rd_data), 16'(e));
  endtask
  task automatic unl(input logic [7:0] c, input int e);
    w(12'hff8, 8'h73, 0);
    w(12'hff8, 8'h8c, 0);
    w(12'hff8, c, e);
  endtask
  // ************************
  // scenarios
  // ************************
  task automatic t_regs;
    w(12'hff8, 8'h00, 0);
    w(12'hff9, 8'h02, 0);
    w(12'hff8, 8'h5e, 0);
    r(12'hff9, 9'h100);
    w(12'hff8, 8'h00, 0);
    r(12'hff9, 9'h102);
    r(12'hff7, 9'h000);
    $display("t_regs done");
  endtask
  task automatic t_mass;
    p(14'h0400, 8'h00, 0);
    p(14'h0001, 8'h00, 0);
    unl(8'h63, 16);
    chk(16'(enabled), 16'h0001);
    f(14'h0400, 8'hff);
    p(14'h0400, 8'ha5, 25);
    p(14'h0400, 8'h0f, 25);
    f(14'h0400, 8'h05);
    w(12'hff8, 8'h00, 0);
    chk(16'(enabled), 16'h0000);
    p(14'h0400, 8'h00, 0);
    f(14'h0400, 8'h05);
    $display("t_mass done");
  endtask
  task automatic t_page;
    w(12'hff9, 8'h03, 0);
    unl(8'h95, 16);
    p(14'h0600, 8'h3c, 25);
    p(14'h0800, 8'h00, 0);
    f(14'h0600, 8'h3c);
    f(14'h0800, 8'hff);
    w(12'hff8, 8'h00, 0);
    unl(8'h95, 16);
    f(14'h0600, 8'hff);
    f(14'h0400, 8'h05);
    $display("t_page done");
  endtask
  task automatic t_protect;
    w(12'hff8, 8'h00, 0);
    w(12'hff8, 8'h5e, 0);
    w(12'hff9, 8'h01, 0);
    w(12'hff9, 8'h00, 0);
    w(12'hff9, 8'h04, 0);
    r(12'hff9, 9'h105);
    w(12'hff8, 8'h00, 0);
    unl(8'h63, 0);
    chk(16'(enabled), 16'h0000);
    w(12'hff9, 8'h02, 0);
    unl(8'h95, 0);
    f(14'h0400, 8'h05);
    $display("t_protect done");
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    rst_b_i = 1'b1;
    t_regs();
    t_mass();
    t_page();
    t_protect();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
